// ---- chip_select_flash_machine.sv ----
/*
  General-purpose chip-select machine for one asynchronous flash bank, with the boot
  sequence that reads the reset configuration word and the reset vector fetch.
  Assumes it is the only bus master and that the pins are sampled on i_sys_clk.
*/
// Functional notes
// - After power-on reset bank zero uses the general machine, base 0xfe000000.
// - Boot decode window of bank zero spans 32 MB.
// - Boot timing is relaxed (pair 10) with 15 wait states.
// - Reset sequence reads a 32-bit configuration word from flash via bank zero.
// - After hard reset release, fetch starts at the reset vector pointer.
// - Write data is driven from the first clock edge of the access.
// - Buffer signals assert on first clock, negate on the acknowledge clock.
// - Buffer disable option keeps both buffer signals inactive.
// - Negation option drops select and write strobe before the address.
// - Setup field 00 asserts select together with the new address.
// - Wait-state field sets inserted wait clocks; 0111 gives seven.
// - External acknowledge option 0 means acknowledge is generated internally.
// - Relaxed pair 10 inserts four idle cycles after a read.
// - Relaxed timing delays strobe start so buffered paths avoid contention.
// - On writes, select stays asserted for a hold after write strobe negates.
// - Transactions wider than the port split into back-to-back port-wide cycles.
// - Machine-select field decides whether this machine serves the bank.
`timescale 1ns/10ps
module chip_select_flash_machine
  import chip_select_pkg::*;
(
  // Clock and power-on reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_n,
  // Reset configuration straps and vector
  input  wire logic                       i_config_source_select,
  input  wire logic                       i_reset_config_input,
  input  wire logic [chip_select_pkg::ADDR_W-1:0] i_reset_vector,
  // Bank configuration
  input  wire logic                       i_cfg_write,
  input  wire chip_select_pkg::bank_base_t   i_cfg_base,
  input  wire chip_select_pkg::bank_option_t i_cfg_option,
  output chip_select_pkg::bank_base_t     o_cfg_base,
  output chip_select_pkg::bank_option_t   o_cfg_option,
  // Boot results
  output logic                            o_hard_reset_line_n,
  output logic [chip_select_pkg::DATA_W-1:0] o_reset_config_word,
  output logic                            o_fetch_valid,
  output logic [chip_select_pkg::DATA_W-1:0] o_fetch_word,
  // Internal requests
  input  wire logic                       i_req_valid,
  input  wire chip_select_pkg::mem_req_t  i_req,
  output logic                            o_req_ready,
  output logic                            o_rsp_valid,
  output logic                            o_rsp_refused,
  output logic [chip_select_pkg::DATA_W-1:0] o_rsp_data,
  // External memory bus
  output logic [chip_select_pkg::ADDR_W-1:0] o_addr,
  output logic [chip_select_pkg::DATA_W-1:0] o_data_out,
  output logic                            o_data_oe,
  input  wire logic [chip_select_pkg::DATA_W-1:0] i_data_in,
  output logic                            o_boot_bank_select_n,
  output logic                            o_read_output_strobe_n,
  output logic                            o_write_strobe_n,
  output logic                            o_buffer_direction_n,
  output logic                            o_buffer_output_enable_n,
  output logic                            o_data_valid_strobe_n,
  input  wire logic                       i_transfer_acknowledge_n
);
  import chip_select_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic bank_hit(input logic [ADDR_W-1:0] a, input logic [FIELD_W-1:0] b,
                                    input logic [FIELD_W-1:0] m);
    bank_hit = (((a[ADDR_W-1:FIELD_LSB] ^ b) & m) == '0);
  endfunction

  function automatic logic [BEAT_W-1:0] beats_of(input logic [1:0] ps);
    unique case (ps)
      PORT_8:  beats_of = 3'h4;
      PORT_16: beats_of = 3'h2;
      default: beats_of = 3'h1;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] bytes_of(input logic [1:0] ps);
    unique case (ps)
      PORT_8:  bytes_of = 32'h1;
      PORT_16: bytes_of = 32'h2;
      default: bytes_of = 32'h4;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] merge_beat(input logic [DATA_W-1:0] acc, input logic [DATA_W-1:0] din,
                                                   input logic [1:0] ps);
    unique case (ps)
      PORT_8:  merge_beat = {din[7:0], acc[31:8]};
      PORT_16: merge_beat = {din[15:0], acc[31:16]};
      default: merge_beat = din;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] shift_beat(input logic [DATA_W-1:0] d, input logic [1:0] ps);
    unique case (ps)
      PORT_8:  shift_beat = {8'h00, d[31:8]};
      PORT_16: shift_beat = {16'h0000, d[31:16]};
      default: shift_beat = d;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bank_base_t        base_q;
  bank_option_t      opt_q;
  phase_t            phase_q;
  bus_state_t        state_q, state_d;
  logic              hard_rel_q;
  logic [ADDR_W-1:0] xfer_addr_q;
  logic [DATA_W-1:0] wdata_q, rdata_q, rdata_next;
  logic              write_q;
  logic [BEAT_W-1:0] beats_left_q;
  logic              start, refuse, straps_low, general_purpose_select_machine_hit, bus_idle, ack_fire, last_beat, read_gap;
  logic [ADDR_W-1:0] start_addr;
  logic [DATA_W-1:0] start_wdata;
  logic              start_write, cnt_load, cnt_last, sel_on, strobe_on, buf_on;
  logic [WAIT_W-1:0] cnt_value;

  assign straps_low = !i_config_source_select && !i_reset_config_input;
  assign general_purpose_select_machine_hit   = bank_hit(i_req.addr, base_q.base, opt_q.window_mask)
                      && (base_q.machine_choice == MACHINE_GENERAL);
  assign bus_idle   = (state_q == BUS_IDLE);
  assign ack_fire   = (state_q == BUS_ACK) && (!opt_q.external_ack_option || !i_transfer_acknowledge_n);
  assign last_beat  = (beats_left_q == BEAT_W'(1));
  assign read_gap   = opt_q.relaxed_timing && !opt_q.extended_hold;
  assign rdata_next = merge_beat(rdata_q, i_data_in, base_q.port_size);

  // ----------------------------------------------------------------
  // Bank configuration
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_q <= BOOT_BANK_BASE;
      opt_q  <= BOOT_BANK_OPTION;
    end else if (i_cfg_write && bus_idle && (phase_q == PH_RUN)) begin
      base_q <= i_cfg_base;
      opt_q  <= i_cfg_option;
    end
  end
  assign o_cfg_base   = base_q;
  assign o_cfg_option = opt_q;

  // ----------------------------------------------------------------
  // Request selection
  // ----------------------------------------------------------------
  always_comb begin
    start       = 1'b0;
    refuse      = 1'b0;
    start_addr  = i_req.addr;
    start_wdata = i_req.wdata;
    start_write = i_req.write;
    unique case (phase_q)
      PH_CONFIG_GO: begin
        start       = straps_low;
        start_addr  = {BOOT_BASE_FIELD, FIELD_LSB'(0)} + CFG_WORD_OFFSET;
        start_write = 1'b0;
      end
      PH_VECTOR_GO: begin
        start       = bus_idle;
        start_addr  = i_reset_vector;
        start_write = 1'b0;
      end
      PH_RUN: begin
        start  = i_req_valid && bus_idle && general_purpose_select_machine_hit;
        refuse = i_req_valid && bus_idle && !general_purpose_select_machine_hit;
      end
      PH_CONFIG_WAIT, PH_VECTOR_WAIT: begin
      end
    endcase
  end
  assign o_req_ready = (phase_q == PH_RUN) && bus_idle;

  // ----------------------------------------------------------------
  // Boot sequencing
  // ----------------------------------------------------------------
  // Hard reset stays low until the configuration word is in hand, or for one clock when the straps are not both low
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q    <= PH_CONFIG_GO;
      hard_rel_q <= 1'b0;
    end else begin
      unique case (phase_q)
        PH_CONFIG_GO: begin
          phase_q    <= straps_low ? PH_CONFIG_WAIT : PH_VECTOR_GO;
          hard_rel_q <= !straps_low;
        end
        PH_CONFIG_WAIT: if (ack_fire && last_beat) begin
          phase_q    <= PH_VECTOR_GO;
          hard_rel_q <= 1'b1;
        end
        PH_VECTOR_GO: if (start) begin
          phase_q <= PH_VECTOR_WAIT;
        end
        PH_VECTOR_WAIT: if (ack_fire && last_beat) begin
          phase_q <= PH_RUN;
        end
        PH_RUN: begin
        end
      endcase
    end
  end
  assign o_hard_reset_line_n = hard_rel_q;

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reset_config_word <= '0;
      o_fetch_word        <= '0;
      o_fetch_valid       <= 1'b0;
      o_rsp_valid         <= 1'b0;
      o_rsp_refused       <= 1'b0;
      o_rsp_data          <= '0;
    end else begin
      o_fetch_valid <= (phase_q == PH_VECTOR_WAIT) && ack_fire && last_beat;
      o_rsp_valid   <= refuse || ((phase_q == PH_RUN) && ack_fire && last_beat);
      o_rsp_refused <= refuse;
      if ((phase_q == PH_CONFIG_WAIT) && ack_fire && last_beat) begin
        o_reset_config_word <= rdata_next;
      end
      if ((phase_q == PH_VECTOR_WAIT) && ack_fire && last_beat) begin
        o_fetch_word <= rdata_next;
      end
      if ((phase_q == PH_RUN) && ack_fire && last_beat) begin
        o_rsp_data <= write_q ? '0 : rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    cnt_load  = 1'b0;
    cnt_value = opt_q.wait_state_count;
    unique case (state_q)
      BUS_IDLE:  if (start) state_d = BUS_SETUP;
      BUS_SETUP: begin
        cnt_load = (opt_q.wait_state_count != '0);
        state_d  = cnt_load ? BUS_WAIT : BUS_ACK;
      end
      BUS_WAIT:  if (cnt_last) state_d = BUS_ACK;
      BUS_ACK: if (ack_fire) begin
        if (write_q) begin
          state_d = BUS_HOLD;
        end else if (!last_beat) begin
          state_d = BUS_SETUP;
        end else if (read_gap) begin
          state_d   = BUS_GAP;
          cnt_load  = 1'b1;
          cnt_value = READ_IDLE_COUNT;
        end else begin
          state_d = BUS_IDLE;
        end
      end
      BUS_HOLD: begin
        if (opt_q.select_negation_timing) state_d = BUS_ADDR_HOLD;
        else state_d = (beats_left_q != '0) ? BUS_SETUP : BUS_IDLE;
      end
      BUS_ADDR_HOLD: state_d = (beats_left_q != '0) ? BUS_SETUP : BUS_IDLE;
      BUS_GAP:   if (cnt_last) state_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  wait_state_counter #(.W(WAIT_W)) u_wait (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n),
    .i_load    (cnt_load),
    .i_value   (cnt_value),
    .o_last    (cnt_last)
  );

  // ----------------------------------------------------------------
  // Transfer datapath
  // ----------------------------------------------------------------
  // Address and data advance only when the next beat starts, so they hold through the hold states
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_addr_q  <= '0;
      wdata_q      <= '0;
      rdata_q      <= '0;
      write_q      <= 1'b0;
      beats_left_q <= '0;
    end else if (start) begin
      xfer_addr_q  <= start_addr;
      wdata_q      <= start_wdata;
      rdata_q      <= '0;
      write_q      <= start_write;
      beats_left_q <= beats_of(base_q.port_size);
    end else begin
      if (ack_fire) begin
        beats_left_q <= beats_left_q - BEAT_W'(1);
        rdata_q      <= rdata_next;
      end
      if ((state_d == BUS_SETUP) && !bus_idle) begin
        xfer_addr_q <= xfer_addr_q + bytes_of(base_q.port_size);
        wdata_q     <= shift_beat(wdata_q, base_q.port_size);
      end
    end
  end
  assign o_addr     = xfer_addr_q;
  assign o_data_out = wdata_q;

  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------
  // One clock stands in for the quarter-clock steps the pad timing would give
  assign sel_on    = ((state_q == BUS_SETUP) && (opt_q.address_to_select_setup == SETUP_WITH_ADDR))
                     || (state_q == BUS_WAIT) || (state_q == BUS_ACK) || (state_q == BUS_HOLD);
  assign strobe_on = ((state_q == BUS_SETUP) && !opt_q.relaxed_timing)
                     || (state_q == BUS_WAIT) || (state_q == BUS_ACK);
  assign buf_on    = !opt_q.buffer_control_disable
                     && ((state_q == BUS_SETUP) || (state_q == BUS_WAIT) || ((state_q == BUS_ACK) && !ack_fire));

  assign o_boot_bank_select_n     = !sel_on;
  assign o_read_output_strobe_n   = !(strobe_on && !write_q);
  assign o_write_strobe_n         = !(strobe_on && write_q);
  assign o_buffer_direction_n     = !buf_on;
  assign o_buffer_output_enable_n = !buf_on;
  assign o_data_valid_strobe_n    = !ack_fire;
  assign o_data_oe                = write_q && !bus_idle && (state_q != BUS_GAP);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  sequence wait_run_s;
    (state_q == BUS_WAIT) [*7] ##1 (state_q == BUS_ACK);
  endsequence
  sequence gap_run_s;
    (state_q == BUS_GAP) [*4] ##1 (state_q == BUS_IDLE);
  endsequence

  boot_base_a: assert property ($rose(rst_n) |-> base_q.base == BOOT_BASE_FIELD
    && base_q.machine_choice == MACHINE_GENERAL) else $error("boot base wrong");
  boot_window_a: assert property ($rose(rst_n) |-> opt_q.window_mask == BOOT_MASK_FIELD)
    else $error("boot window wrong");
  boot_timing_a: assert property ($rose(rst_n) |-> opt_q.relaxed_timing && !opt_q.extended_hold
    && opt_q.wait_state_count == BOOT_WAIT_COUNT) else $error("boot timing wrong");
  config_read_a: assert property (phase_q == PH_CONFIG_GO && straps_low
    |=> state_q == BUS_SETUP && o_addr == {BOOT_BASE_FIELD, FIELD_LSB'(0)}) else $error("config read missing");
  vector_fetch_a: assert property (phase_q == PH_VECTOR_GO && bus_idle
    |-> o_hard_reset_line_n ##1 o_addr == $past(i_reset_vector)) else $error("vector fetch wrong");
  write_data_a: assert property (state_q == BUS_SETUP && write_q |-> o_data_oe) else $error("write data late");
  buffer_window_a: assert property (state_q == BUS_SETUP && !opt_q.buffer_control_disable
    |-> !o_buffer_output_enable_n && !o_buffer_direction_n) else $error("buffer timing");
  buffer_drop_a: assert property (ack_fire |-> o_buffer_output_enable_n && o_buffer_direction_n)
    else $error("buffer late");
  relaxed_start_a: assert property (state_q == BUS_SETUP && opt_q.relaxed_timing
    |-> o_read_output_strobe_n && o_write_strobe_n) else $error("strobe early");
  buffer_quiet_a: assert property (opt_q.buffer_control_disable
    |-> o_buffer_direction_n && o_buffer_output_enable_n) else $error("buffer not disabled");
  select_early_a: assert property (state_q == BUS_HOLD && opt_q.select_negation_timing
    |=> o_boot_bank_select_n && o_write_strobe_n && $stable(o_addr)) else $error("negation order");
  select_setup_a: assert property (state_q == BUS_SETUP && opt_q.address_to_select_setup == SETUP_WITH_ADDR
    |-> !o_boot_bank_select_n) else $error("select late");
  wait_count_a: assert property (state_q == BUS_SETUP && opt_q.wait_state_count == 4'h7
    |=> wait_run_s) else $error("wait count wrong");
  internal_ack_a: assert property (state_q == BUS_ACK && !opt_q.external_ack_option
    |-> !o_data_valid_strobe_n ##1 state_q != BUS_ACK) else $error("no internal ack");
  read_gap_a: assert property (ack_fire && !write_q && last_beat && read_gap |=> gap_run_s)
    else $error("read gap wrong");
  write_hold_a: assert property (ack_fire && write_q
    |=> !o_boot_bank_select_n && o_write_strobe_n) else $error("no select hold");
  machine_skip_a: assert property (refuse |=> bus_idle && o_rsp_valid && o_rsp_refused)
    else $error("foreign bank served");

endmodule

// ---- chip_select_pkg.sv ----
/*
  Constants, field layouts and types shared by the chip-select flash machine.
  Assumes one 32-bit address space with a single external bank decoded from bit 15 upward.
*/
package chip_select_pkg;

  // ----------------------------------------------------------------
  // Widths and field layout
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 32;
  localparam int DATA_W    = 32;
  localparam int FIELD_LSB = 15;
  localparam int FIELD_W   = ADDR_W - FIELD_LSB;
  localparam int WAIT_W    = 4;
  localparam int BEAT_W    = 3;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MACHINE_GENERAL = 3'h0;
  localparam logic [1:0] PORT_32         = 2'h0;
  localparam logic [1:0] PORT_8          = 2'h1;
  localparam logic [1:0] PORT_16         = 2'h2;
  localparam logic [1:0] SETUP_WITH_ADDR = 2'h0;

  // ----------------------------------------------------------------
  // Boot defaults and fixed timing
  // ----------------------------------------------------------------
  localparam logic [FIELD_W-1:0] BOOT_BASE_FIELD = 17'h1fc00;
  localparam logic [FIELD_W-1:0] BOOT_MASK_FIELD = 17'h1fc00;
  localparam logic [ADDR_W-1:0]  CFG_WORD_OFFSET = 32'h0000_0000;
  localparam logic [WAIT_W-1:0]  BOOT_WAIT_COUNT = 4'hf;
  localparam logic [WAIT_W-1:0]  READ_IDLE_COUNT = 4'h4;
  localparam logic [1:0]         BOOT_PORT_SIZE  = PORT_16;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [FIELD_W-1:0] base;
    logic [2:0]         machine_choice;
    logic [1:0]         port_size;
  } bank_base_t;

  typedef struct packed {
    logic [FIELD_W-1:0] window_mask;
    logic               relaxed_timing;
    logic               extended_hold;
    logic [WAIT_W-1:0]  wait_state_count;
    logic               select_negation_timing;
    logic [1:0]         address_to_select_setup;
    logic               external_ack_option;
    logic               buffer_control_disable;
  } bank_option_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
  } mem_req_t;

  localparam bank_base_t BOOT_BANK_BASE = '{base: BOOT_BASE_FIELD, machine_choice: MACHINE_GENERAL,
                                            port_size: BOOT_PORT_SIZE};
  localparam bank_option_t BOOT_BANK_OPTION = '{window_mask: BOOT_MASK_FIELD, relaxed_timing: 1'b1,
                                                extended_hold: 1'b0, wait_state_count: BOOT_WAIT_COUNT,
                                                select_negation_timing: 1'b0,
                                                address_to_select_setup: SETUP_WITH_ADDR,
                                                external_ack_option: 1'b0, buffer_control_disable: 1'b0};

  typedef enum logic [2:0] {BUS_IDLE, BUS_SETUP, BUS_WAIT, BUS_ACK, BUS_HOLD, BUS_ADDR_HOLD, BUS_GAP} bus_state_t;
  typedef enum logic [2:0] {PH_CONFIG_GO, PH_CONFIG_WAIT, PH_VECTOR_GO, PH_VECTOR_WAIT, PH_RUN} phase_t;

endpackage

// ---- wait_state_counter.sv ----
/*
  Loadable down counter that times wait states and idle gaps.
  Assumes a load and a count never overlap a running interval.
*/
`timescale 1ns/10ps
module wait_state_counter #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  // Control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  // Status
  output logic              o_last
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= i_value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign o_last = (cnt_q == W'(1));

endmodule

// ---- flash_model.sv ----
/*
  Behavioural flash partner: answers reads, keeps the last write.
  Assumes active-low select and strobes from the chip-select machine.
*/
`timescale 1ns/10ps
module flash_model (
  // Bus side
  input  wire logic [31:0] i_addr,
  input  wire logic        i_sel_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [31:0] i_data,
  output logic      [31:0] o_data
);
  logic [31:0] waddr_q = 32'hffff_ffff;
  logic [31:0] wdata_q = 32'h0;
  logic [31:0] last_q  = 32'h0;
  wire         wr_n    = i_we_n | i_sel_n;
  // Address is steady through the beat; the small delay keeps clear of the launching edge
  always @(negedge wr_n) #1 waddr_q = i_addr;
  always @(posedge wr_n) wdata_q = i_data;
  // Released bus shows the inverse so stale data never passes
  always @* begin
    if (!i_sel_n && !i_oe_n) begin
      o_data = (i_addr == waddr_q) ? wdata_q : i_addr ^ 32'h5a5a_c3c3;
      last_q = o_data;
    end else o_data = ~last_q;
  end
endmodule

// ---- tb_top.sv ----
/*
  Testbench for the chip-select flash machine: boot, timing, split and refusal.
  Assumes flash_model on the bus and straps held low until the second reset, which raises them.
*/
`timescale 1ns/10ps
module tb_top;
  import chip_select_pkg::*;
  logic i_sys_clk = 0, i_rst_n = 0, i_cfg_write = 0, i_req_valid = 0, bufs = 0, straps = 0;
  logic rdy, rv, rf, sel_n, oe_n, we_n, bo_n, bd_n, hrn;
  bank_base_t cb, o_cb;
  bank_option_t co, o_co;
  mem_req_t i_req = '0;
  logic [31:0] cw, fw, rd, addr, dout, din;
  int num_errors = 0, checks = 0, n;
  always #5 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk) if (bo_n === 1'b0 || bd_n === 1'b0) bufs = 1;
  chip_select_flash_machine dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_config_source_select(straps),
    .i_reset_config_input(1'b0), .i_reset_vector(32'hfe00_0100), .i_cfg_write(i_cfg_write), .i_cfg_base(cb),
    .i_cfg_option(co), .o_cfg_base(o_cb), .o_cfg_option(o_co), .o_hard_reset_line_n(hrn), .o_reset_config_word(cw),
    .o_fetch_valid(), .o_fetch_word(fw), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(rdy),
    .o_rsp_valid(rv), .o_rsp_refused(rf), .o_rsp_data(rd), .o_addr(addr), .o_data_out(dout), .o_data_oe(),
    .i_data_in(din), .o_boot_bank_select_n(sel_n), .o_read_output_strobe_n(oe_n), .o_write_strobe_n(we_n),
    .o_buffer_direction_n(bd_n), .o_buffer_output_enable_n(bo_n), .o_data_valid_strobe_n(),
    .i_transfer_acknowledge_n(1'b1));
  flash_model mem (.i_addr(addr), .i_sel_n(sel_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_data(dout), .o_data(din));
  function automatic logic [31:0] beats(input logic [31:0] a, input int sz);
    logic [63:0] r;
    r = 0;
    for (int k = 0; k < 32 / sz; k++) r |= (((a + k * sz / 8) ^ 64'h5a5a_c3c3) & ((64'h1 << sz) - 1)) << (k * sz);
    return r[31:0];
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    @(negedge i_sys_clk);
    while (rdy !== 1'b1 && k < 2000) begin
      @(negedge i_sys_clk);
      k++;
    end
  endtask
  task automatic cfg;
    wait_ready;
    i_cfg_write = 1;
    @(negedge i_sys_clk);
    i_cfg_write = 0;
  endtask
  // Cycles counted from the taking edge to the response pulse
  task automatic xfer(input logic w, input logic [31:0] a, d);
    wait_ready;
    i_req_valid = 1;
    i_req = '{addr: a, wdata: d, write: w};
    @(negedge i_sys_clk);
    i_req_valid = 0;
    n = 0;
    while (rv !== 1'b1 && n < 500) begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    num_errors++;
    give_verdict;
  end
  initial begin
    cb = BOOT_BANK_BASE;
    co = BOOT_BANK_OPTION;
    repeat (3) @(negedge i_sys_clk);
    i_rst_n = 1;
    wait_ready;
    chk("boot_base", o_cb, BOOT_BANK_BASE);
    chk("boot_option", o_co, BOOT_BANK_OPTION);
    chk("config_word", cw, beats(32'hfe00_0000, 16));
    chk("fetch_word", fw, beats(32'hfe00_0100, 16));
    chk("hard_reset_free", hrn, 1);
    cb.port_size = PORT_32;
    {co.relaxed_timing, co.wait_state_count, co.select_negation_timing, co.buffer_control_disable} = 7'b0_0111_1_1;
    cfg;
    bufs = 0;
    xfer(1, 32'hfe00_0040, 32'h1234_abcd);
    xfer(0, 32'hfe00_0040, 0);
    chk("write_back", rd, 32'h1234_abcd);
    xfer(0, 32'hfe00_0080, 0);
    chk("read32", rd, beats(32'hfe00_0080, 32));
    chk("latency", n, 1 + 7 + 1);
    chk("buffers_off", bufs, 0);
    co.buffer_control_disable = 0;
    cb.port_size = PORT_8;
    cfg;
    xfer(0, 32'hfe00_0010, 0);
    chk("read8", rd, beats(32'hfe00_0010, 8));
    chk("buffers_on", bufs, 1);
    xfer(0, 32'h1000_0000, 0);
    chk("miss", {n[7:0], rf}, 9'h1);
    cb.machine_choice = 3'h1;
    cfg;
    xfer(0, 32'hfe00_0000, 0);
    chk("other_machine", rf, 1);
    // Second reset with the straps high: no configuration read, vector fetch still runs
    straps = 1;
    i_rst_n = 0;
    @(negedge i_sys_clk);
    chk("hard_reset_held", hrn, 0);
    repeat (2) @(negedge i_sys_clk);
    i_rst_n = 1;
    wait_ready;
    chk("no_config_read", cw, 0);
    chk("hard_reset_again", hrn, 1);
    chk("fetch_again", fw, beats(32'hfe00_0100, 16));
    give_verdict;
  end
endmodule
